// ==== src/icrs_top.sv ====
// powered side sequencer of the isolated compare result path
`timescale 1ns/1ps
`default_nettype none
module icrs_top
   import icrs_pkg::*;
#(
   parameter int IN_W        = 8,
   parameter int HALF_CYCLES = PL_HALF_CYC
) (
   input  wire logic            clock_i,
   input  wire logic            rst_i,
   input  wire logic            power_down_n_i,
   input  wire logic            zero_cross_in_p_i,
   input  wire logic            zero_cross_in_n_i,
   input  wire logic            isolated_storage_supply_ok_i,
   input  wire logic            isolated_por_i,
   input  wire logic            link_noise_i,
   input  wire logic [IN_W-1:0] pos_input_a_i,
   input  wire logic [IN_W-1:0] pos_input_b_i,
   input  wire logic [IN_W-1:0] neg_input_a_i,
   input  wire logic [IN_W-1:0] neg_input_b_i,
   output logic                 result_data_o,
   output logic                 result_valid_o,
   output logic                 zero_cross_trigger_pulse_o,
   output logic                 listen_phase_o,
   output logic                 isolated_regulated_rail_o,
   output logic                 isolated_result_out_o,
   output logic                 isolated_result_out_oe_o,
   output logic                 isolated_cmp_enable_o
);

   // ******************************************************************
   // elaboration checks
   // ******************************************************************
   // the whole rail window must fit in one listen half
   if (HALF_CYCLES <= RAIL_CYC + 4 || HALF_CYCLES >= (1 << CYC_W)) begin : g_bad_half
      $error("HALF_CYCLES out of range");
   end
   if (IN_W < 1) begin : g_bad_w
      $error("IN_W must be positive");
   end

   // ******************************************************************
   // state
   // ******************************************************************
   typedef struct packed {
      icrs_phase_t      phase;
      logic [CYC_W-1:0] cyc;
      logic             pd_s1;
      logic             pd_s2;
      logic             zp_s1;
      logic             zp_s2;
      logic             zn_s1;
      logic             zn_s2;
      logic             nz_s1;
      logic             nz_s2;
      logic             zc_prev;
      logic             got;
      logic             got_ok;
      logic             got_bit;
      logic             data;
      logic             valid;
      logic             vpend;
      logic [1:0]       vdly;
      logic             zc_pulse;
      logic [ZC_W-1:0]  zc_cnt;
      logic             listen_start;
   } icrs_top_t;

   localparam logic [CYC_W-1:0] LAST_CYC = CYC_W'(HALF_CYCLES - 1);

   icrs_top_t  s;
   icrs_top_t  next_s;
   logic       iso_rail;
   logic       iso_out;
   logic       iso_oe;
   logic       iso_cmp_en;
   logic [2:0] iso_code;
   logic       iso_code_valid;
   logic       pd_active;
   logic       half_end;
   logic       zc_level;
   logic       zc_edge;

   // ******************************************************************
   // isolated side
   // ******************************************************************
   icrs_iso_side #(
      .IN_W (IN_W)
   ) u_iso (
      .clock_i        (clock_i),
      .rst_i          (rst_i),
      .listen_start_i (s.listen_start),
      .supply_ok_i    (isolated_storage_supply_ok_i),
      .por_i          (isolated_por_i),
      .pos_a_i        (pos_input_a_i),
      .pos_b_i        (pos_input_b_i),
      .neg_a_i        (neg_input_a_i),
      .neg_b_i        (neg_input_b_i),
      .rail_o         (iso_rail),
      .result_o       (iso_out),
      .result_oe_o    (iso_oe),
      .cmp_en_o       (iso_cmp_en),
      .code_o         (iso_code),
      .code_valid_o   (iso_code_valid)
   );

   // ******************************************************************
   // decode helpers
   // ******************************************************************
   // only the second sync stages are looked at here
   always_comb begin
      pd_active = !s.pd_s2;
      half_end  = (s.cyc == LAST_CYC);
      zc_level  = s.zp_s2 && !s.zn_s2;
      zc_edge   = (zc_level != s.zc_prev);
   end

   // ******************************************************************
   // next state
   // ******************************************************************
   always_comb begin
      next_s              = s;
      next_s.listen_start = 1'b0;
      next_s.pd_s1        = power_down_n_i;
      next_s.pd_s2        = s.pd_s1;
      next_s.zp_s1        = zero_cross_in_p_i;
      next_s.zp_s2        = s.zp_s1;
      next_s.zn_s1        = zero_cross_in_n_i;
      next_s.zn_s2        = s.zn_s1;
      next_s.nz_s1        = link_noise_i;
      next_s.nz_s2        = s.nz_s1;
      next_s.zc_prev      = zc_level;
      if (pd_active) begin
         // shutdown: everything parked, result forced low
         next_s.phase    = ICRS_POWER;
         next_s.cyc      = '0;
         next_s.data     = DATA_RST;
         next_s.valid    = 1'b0;
         next_s.vpend    = 1'b0;
         next_s.vdly     = '0;
         next_s.got      = 1'b0;
         next_s.zc_pulse = 1'b0;
         next_s.zc_cnt   = '0;
      end else begin
         // power and listen halves alternate forever
         if (half_end) begin
            next_s.cyc = '0;
            if (s.phase == ICRS_POWER) begin
               next_s.phase        = ICRS_LISTEN;
               next_s.listen_start = 1'b1;
               next_s.valid        = 1'b0;
               next_s.vpend        = 1'b0;
               next_s.got          = 1'b0;
            end else begin
               next_s.phase = ICRS_POWER;
               if (s.got && s.got_ok) begin
                  next_s.data  = s.got_bit;
                  next_s.vpend = 1'b1;
                  next_s.vdly  = '0;
               end
            end
         end else begin
            next_s.cyc = s.cyc + CYC_W'(1);
         end
         // pulses come back only during listen; noise flips the middle copy
         if (iso_code_valid && s.phase == ICRS_LISTEN) begin
            next_s.got     = 1'b1;
            next_s.got_ok  = icrs_agree(iso_code ^ {1'b0, s.nz_s2, 1'b0});
            next_s.got_bit = iso_code[2];
         end
         // strobe trails the data so its rising edge can clock it in
         if (s.vpend) begin
            if (s.vdly == 2'(VALID_DLY_CYC - 1)) begin
               next_s.valid = 1'b1;
               next_s.vpend = 1'b0;
            end else begin
               next_s.vdly = s.vdly + 2'h1;
            end
         end
         // trigger: fixed width, ignores crossings while already high
         if (s.zc_pulse) begin
            if (s.zc_cnt == ZC_W'(ZC_PULSE_CYC - 1)) begin
               next_s.zc_pulse = 1'b0;
            end else begin
               next_s.zc_cnt = s.zc_cnt + ZC_W'(1);
            end
         end else if (zc_edge && s.data) begin
            next_s.zc_pulse = 1'b1;
            next_s.zc_cnt   = '0;
         end
      end
   end

   // ******************************************************************
   // registers
   // ******************************************************************
   // reset clears the result too, as at power-up
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ******************************************************************
   // outputs, all from flops
   // ******************************************************************
   assign result_data_o              = s.data;
   assign result_valid_o             = s.valid;
   assign zero_cross_trigger_pulse_o = s.zc_pulse;
   assign listen_phase_o             = s.phase;
   assign isolated_regulated_rail_o  = iso_rail;
   assign isolated_result_out_o      = iso_out;
   assign isolated_result_out_oe_o   = iso_oe;
   assign isolated_cmp_enable_o      = iso_cmp_en;

   // ******************************************************************
   // checks
   // ******************************************************************
   property p_pd_forces_zero;
      @(posedge clock_i) disable iff (rst_i) !s.pd_s2 |=> !s.data && !s.valid && !s.zc_pulse;
   endproperty
   a_pd_forces_zero: assert property (p_pd_forces_zero) else $error("shutdown left outputs up");

   property p_phase_period;
      @(posedge clock_i) disable iff (rst_i)
         (s.pd_s2 && s.phase == ICRS_POWER && half_end && $past(s.pd_s1) && s.pd_s1)
         |=> s.phase == ICRS_LISTEN && s.cyc == '0 && s.listen_start;
   endproperty
   a_phase_period: assert property (p_phase_period) else $error("listen did not start");

   property p_cyc_bound;
      @(posedge clock_i) disable iff (rst_i) s.cyc <= LAST_CYC;
   endproperty
   a_cyc_bound: assert property (p_cyc_bound) else $error("cycle count overran");

   property p_reject_keeps;
      @(posedge clock_i) disable iff (rst_i)
         (s.pd_s2 && s.phase == ICRS_LISTEN && half_end && !(s.got && s.got_ok))
         |=> $stable(s.data) || !$past(s.pd_s2);
   endproperty
   a_reject_keeps: assert property (p_reject_keeps) else $error("data moved on rejected cycle");

   property p_data_cause;
      @(posedge clock_i) disable iff (rst_i)
         ($changed(s.data) && $past(s.pd_s2))
         |-> $past(s.phase == ICRS_LISTEN && half_end && s.got && s.got_ok);
   endproperty
   a_data_cause: assert property (p_data_cause) else $error("data changed without compare");

   property p_valid_delay;
      @(posedge clock_i) disable iff (rst_i)
         (s.pd_s2 && s.pd_s1 && s.phase == ICRS_LISTEN && half_end && s.got && s.got_ok)
         |=> !s.valid ##1 !s.valid ##1 (s.valid || !s.pd_s2);
   endproperty
   a_valid_delay: assert property (p_valid_delay) else $error("valid not 200ns after data");

   property p_valid_falls;
      @(posedge clock_i) disable iff (rst_i) (s.phase == ICRS_POWER && half_end) |=> !s.valid;
   endproperty
   a_valid_falls: assert property (p_valid_falls) else $error("valid high into listen");

   property p_zc_needs_data;
      @(posedge clock_i) disable iff (rst_i) $rose(s.zc_pulse) |-> $past(s.data) && $past(zc_edge);
   endproperty
   a_zc_needs_data: assert property (p_zc_needs_data) else $error("trigger without data");

   property p_zc_width;
      @(posedge clock_i) disable iff (rst_i)
         ($fell(s.zc_pulse) && $past(s.pd_s2)) |-> $past(s.zc_cnt) == ZC_W'(ZC_PULSE_CYC - 1);
   endproperty
   a_zc_width: assert property (p_zc_width) else $error("trigger width wrong");

   c_accept: cover property (@(posedge clock_i) disable iff (rst_i)
      s.phase == ICRS_LISTEN && half_end && s.got && s.got_ok);
   c_reject: cover property (@(posedge clock_i) disable iff (rst_i)
      s.phase == ICRS_LISTEN && half_end && s.got && !s.got_ok);
   c_valid: cover property (@(posedge clock_i) disable iff (rst_i) $rose(s.valid));
   c_trigger: cover property (@(posedge clock_i) disable iff (rst_i) $fell(s.zc_pulse));

endmodule
`default_nettype wire

// ==== src/icrs_pkg.sv ====
// constants and types shared by the isolated compare result sequencer
package icrs_pkg;

   // ******************************************************************
   // clock
   // ******************************************************************
   localparam int CLK_PERIOD_NS = 100;

   // ******************************************************************
   // power-listen cycle
   // ******************************************************************
   localparam int PL_RATE_HZ    = 800;         // inside the 700..900 Hz band
   localparam int PL_PERIOD_NS  = 1000000000 / PL_RATE_HZ;
   localparam int PL_HALF_CYC   = PL_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int CYC_W         = 16;

   // ******************************************************************
   // isolated side timing
   // ******************************************************************
   localparam int RAIL_ON_NS    = 108000;
   localparam int RAIL_CYC      = RAIL_ON_NS / CLK_PERIOD_NS;
   localparam int CMP_EN_NS     = 10000;
   localparam int CMP_EN_CYC    = CMP_EN_NS / CLK_PERIOD_NS;
   localparam int WIN_W         = 11;

   // ******************************************************************
   // powered side output timing
   // ******************************************************************
   localparam int VALID_DLY_NS  = 200;
   localparam int VALID_DLY_CYC = (VALID_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ZC_MIN_NS     = 24000;
   localparam int ZC_MAX_NS     = 30000;
   localparam int ZC_PULSE_NS   = 25000;
   localparam int ZC_PULSE_CYC  = ZC_PULSE_NS / CLK_PERIOD_NS;
   localparam int ZC_W          = 9;

   // ******************************************************************
   // reset values and encodings
   // ******************************************************************
   localparam logic       DATA_RST  = 1'b0;
   localparam logic       STORE_RST = 1'b0;
   localparam logic [2:0] CODE_RST  = 3'h0;

   typedef enum logic [0:0] {
      ICRS_POWER  = 1'b0,
      ICRS_LISTEN = 1'b1
   } icrs_phase_t;

   // triple copy, middle one inverted, so a stuck link never agrees
   function automatic logic [2:0] icrs_encode(input logic r);
      icrs_encode = {r, ~r, r};
   endfunction

   function automatic logic icrs_agree(input logic [2:0] c);
      icrs_agree = (c[2] == c[0]) && (c[1] != c[2]);
   endfunction

endpackage

// ==== src/icrs_iso_side.sv ====
// isolated side: regulated window, sampled compare, latched result pin
`timescale 1ns/1ps
`default_nettype none
module icrs_iso_side
   import icrs_pkg::*;
#(
   parameter int IN_W = 8
) (
   input  wire logic            clock_i,
   input  wire logic            rst_i,
   input  wire logic            listen_start_i,
   input  wire logic            supply_ok_i,
   input  wire logic            por_i,
   input  wire logic [IN_W-1:0] pos_a_i,
   input  wire logic [IN_W-1:0] pos_b_i,
   input  wire logic [IN_W-1:0] neg_a_i,
   input  wire logic [IN_W-1:0] neg_b_i,
   output logic                 rail_o,
   output logic                 result_o,
   output logic                 result_oe_o,
   output logic                 cmp_en_o,
   output logic [2:0]           code_o,
   output logic                 code_valid_o
);

   typedef struct packed {
      logic              ok_s1;
      logic              ok_s2;
      logic              por_s1;
      logic              por_s2;
      logic [4*IN_W-1:0] in_s1;
      logic [4*IN_W-1:0] in_s2;
      logic              active;
      logic [WIN_W-1:0]  wcnt;
      logic              stored;
      logic              rail;
      logic              oe;
      logic              out;
      logic              cmp_en;
      logic [2:0]        code;
      logic              code_valid;
   } icrs_iso_t;

   icrs_iso_t s;
   icrs_iso_t next_s;
   logic      res;

   // ******************************************************************
   // window sequencing
   // ******************************************************************
   // summed compare: (a+b)/2 > (c+d)/2, halves cancel
   always_comb begin
      res = ({1'b0, s.in_s2[4*IN_W-1:3*IN_W]} + {1'b0, s.in_s2[3*IN_W-1:2*IN_W]})
          > ({1'b0, s.in_s2[2*IN_W-1:IN_W]} + {1'b0, s.in_s2[IN_W-1:0]});
   end

   always_comb begin
      next_s            = s;
      next_s.code_valid = 1'b0;
      next_s.ok_s1      = supply_ok_i;
      next_s.ok_s2      = s.ok_s1;
      next_s.por_s1     = por_i;
      next_s.por_s2     = s.por_s1;
      next_s.in_s1      = {pos_a_i, pos_b_i, neg_a_i, neg_b_i};
      next_s.in_s2      = s.in_s1;
      if (!s.active) begin
         // no stored charge, no compare in this listen cycle
         if (listen_start_i && s.ok_s2) begin
            next_s.active = 1'b1;
            next_s.wcnt   = '0;
            next_s.rail   = 1'b1;
            next_s.oe     = 1'b1;
            next_s.out    = s.stored;
         end
      end else if (s.wcnt == WIN_W'(RAIL_CYC - 1)) begin
         next_s.active     = 1'b0;
         next_s.rail       = 1'b0;
         next_s.oe         = 1'b0;
         next_s.out        = 1'b0;
         next_s.cmp_en     = 1'b0;
         next_s.stored     = res;
         next_s.code       = icrs_encode(res);
         next_s.code_valid = 1'b1;
      end else begin
         next_s.wcnt   = s.wcnt + WIN_W'(1);
         next_s.cmp_en = (s.wcnt + WIN_W'(1)) >= WIN_W'(RAIL_CYC - CMP_EN_CYC);
      end
      // isolated power-on reset wins over a fresh sample
      if (s.por_s2) begin
         next_s.stored = STORE_RST;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rail_o       = s.rail;
   assign result_o     = s.out;
   assign result_oe_o  = s.oe;
   assign cmp_en_o     = s.cmp_en;
   assign code_o       = s.code;
   assign code_valid_o = s.code_valid;

   // ******************************************************************
   // checks
   // ******************************************************************
   property p_cmp_in_window;
      @(posedge clock_i) disable iff (rst_i)
         s.cmp_en |-> s.rail && s.wcnt >= WIN_W'(RAIL_CYC - CMP_EN_CYC);
   endproperty
   a_cmp_in_window: assert property (p_cmp_in_window) else $error("compare outside window");

   property p_pin_driven_in_window;
      @(posedge clock_i) disable iff (rst_i) $rose(s.rail) |-> s.oe && (s.out == $past(s.stored));
   endproperty
   a_pin_driven_in_window: assert property (p_pin_driven_in_window) else $error("pin not driven");

endmodule
`default_nettype wire

// ==== tb/icrs_partner.sv ====
// outside logic that clocks the latched result in on the valid strobe
`timescale 1ns/1ps
`default_nettype none
module icrs_partner (
   input  wire logic valid_i,
   input  wire logic data_i,
   output var logic  held_o
);
   // valid rising edge is the capture clock; no reset, like a plain register
   always_ff @(posedge valid_i) held_o <= data_i;
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the powered side sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
   import icrs_pkg::*;
   localparam int HALF = 1200; // short half period keeps the run small
   logic       clock_i = 1'b0;
   logic       rst_i   = 1'b1;
   logic       pdn_n   = 1'b1;
   logic       zp      = 1'b0;
   logic       zn      = 1'b0;
   logic       sup     = 1'b0;
   logic       por     = 1'b0;
   logic       noise   = 1'b0;
   logic [7:0] pa = 8'h00, pb = 8'h00, na = 8'h00, nb = 8'h00;
   logic       data, valid, trig, listen, rail, pin, oe, cen, held;
   int         fail_count = 0;
   int         num_checks = 0;

   // 10 MHz clock
   always #50 clock_i = ~clock_i;

   icrs_top #(.HALF_CYCLES(HALF)) i_icrs_top (
      .clock_i(clock_i), .rst_i(rst_i), .power_down_n_i(pdn_n),
      .zero_cross_in_p_i(zp), .zero_cross_in_n_i(zn),
      .isolated_storage_supply_ok_i(sup), .isolated_por_i(por), .link_noise_i(noise),
      .pos_input_a_i(pa), .pos_input_b_i(pb), .neg_input_a_i(na), .neg_input_b_i(nb),
      .result_data_o(data), .result_valid_o(valid), .zero_cross_trigger_pulse_o(trig),
      .listen_phase_o(listen), .isolated_regulated_rail_o(rail),
      .isolated_result_out_o(pin), .isolated_result_out_oe_o(oe),
      .isolated_cmp_enable_o(cen));

   icrs_partner i_icrs_partner (.valid_i(valid), .data_i(data), .held_o(held));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("Error at %0t: %s", $time, m);
      end
   endtask

   // bounded wait, polled on the falling edge where outputs are settled
   task automatic wait_listen(input logic lvl);
      int n = 0;
      while (listen !== lvl) begin
         @(negedge clock_i);
         n++;
         if (n > 3000) begin
            chk(1'b0, "listen timeout");
            close_out();
         end
      end
   endtask

   // one whole listen half: window timing, pin, then the decision
   task automatic one_pair(input logic [7:0] a, b, c, d, input logic s, z, ed, ev, ep);
      int l = 0, n = 0, f = -1, e = 0, bad = 0;
      {pa, pb, na, nb, sup, noise} = {a, b, c, d, s, z};
      wait_listen(1'b0);
      wait_listen(1'b1);
      chk(valid === 1'b0, "valid not low at listen");
      do begin
         if (rail === 1'b1 && cen === 1'b1 && f < 0) f = n;
         if (rail === 1'b1) n++;
         if (cen === 1'b1) e++;
         if (oe !== rail || (rail === 1'b1 && pin !== ep)) bad++;
         @(negedge clock_i);
         l++;
      end while (listen === 1'b1 && l < 3000);
      chk(l == HALF, "listen length");
      chk(n == (s ? RAIL_CYC : 0), "rail length");
      chk(f == (s ? RAIL_CYC - CMP_EN_CYC : -1), "cmp start");
      chk(e == (s ? CMP_EN_CYC : 0), "cmp length");
      chk(bad == 0, "isolated pin");
      chk(data === ed, "data");
      @(negedge clock_i);
      chk(valid === 1'b0, "valid early");
      // strobe must be up exactly two clocks (200 ns) after the data edge
      @(negedge clock_i);
      chk(valid === ev, "valid");
      if (ev) chk(held === ed, "capture");
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   // crossing, then a second crossing inside the pulse that must be dropped;
   // the second one comes from the negative input so both pins are exercised
   task automatic zc_scn(input logic ex);
      int w = 0;
      zp = 1'b1;
      zn = 1'b0;
      for (int i = 0; i < 400; i++) begin
         @(negedge clock_i);
         if (i == 50) zn = 1'b1;
         if (trig === 1'b1) w++;
      end
      chk(w == (ex ? ZC_PULSE_CYC : 0), "trigger width");
      chk(!ex || (w * CLK_PERIOD_NS >= ZC_MIN_NS && w * CLK_PERIOD_NS <= ZC_MAX_NS),
          "trigger span");
   endtask

   task automatic shut_scn();
      pdn_n = 1'b0;
      repeat (5) @(negedge clock_i);
      chk({data, valid, listen} === 3'h0, "shutdown");
      pdn_n = 1'b1;
      repeat (3) @(negedge clock_i);
   endtask

   task automatic por_scn();
      por = 1'b1;
      repeat (4) @(negedge clock_i);
      por = 1'b0;
      one_pair(8'h0a, 8'h0a, 8'h05, 8'h05, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
   endtask

   initial begin
      repeat (12) @(negedge clock_i);
      rst_i = 1'b0;
      repeat (3) @(negedge clock_i);
      chk({data, valid, trig, rail, oe} === 5'h00, "reset");
      one_pair(8'h0a, 8'h0a, 8'h05, 8'h05, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      zc_scn(1'b1);
      one_pair(8'h05, 8'h05, 8'h05, 8'h05, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
      one_pair(8'h0a, 8'h0a, 8'h05, 8'h05, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      one_pair(8'h05, 8'h05, 8'h05, 8'h05, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      zc_scn(1'b0);
      one_pair(8'h0a, 8'h0a, 8'h05, 8'h05, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      shut_scn();
      one_pair(8'h0a, 8'h0a, 8'h05, 8'h05, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
      por_scn();
      close_out();
   end
endmodule
`default_nettype wire
